// ### design/ddrsg_datapath.sv
// Strobe group data path toward DDR or reduced-latency DRAM, one group.
// Assumes the strobe and data pins are asynchronous to clk and that the
// memory clock produced here is also the phase loop's reference clock.
//
// What this block does
// - Byte-wide mode: one strobe clocks eight lines
// - Sixteen-line mode uses its own strobe position
// - Thirty-two-line mode uses its own strobe position
// - Strobe pin: bidirectional strobe or read clock
// - Odd widths round up; surplus lines stay plain
// - Capture only when bidirectional; else enables low
// - Mask low stores a beat, high skips
// - One write mask output per group
// - Mask launched with write data, quarter early
// - Check bits: encode on write, correct on read
// - Byte parity rides in group, forcing wider mode
// - Memory clock from a toggle register dividing clk
// - Inverted shifted strobe captures read data
// - Phase loop needs 256 reference cycles
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
module ddrsg_datapath
  import ddrsg_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter bit PARITY_EN = 1'b0,
  parameter int MCLK_HALF = ddrsg_pkg::MCLK_HALF_CYC,
  parameter int SETTLE = ddrsg_pkg::SETTLE_REF_CYCLES,
  parameter int MODE_W =
    ddrsg_pkg::groupMode(DATA_W + (PARITY_EN ? DATA_W / 8 : 0))
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ddrsg_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wrValid,
  output logic wrReady_ff,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrSkip,
  input wire logic rdStart,
  output logic rdAllowed_ff,
  output logic [DATA_W-1:0] rdData_ff,
  output logic rdValid_ff,
  input wire logic [ddrsg_pkg::ECC_DATA_W-1:0] eccWrData,
  output logic [ddrsg_pkg::ECC_CODE_W-1:0] eccWrCode,
  input wire logic [ddrsg_pkg::ECC_CODE_W-1:0] eccRdCode,
  output logic [ddrsg_pkg::ECC_DATA_W-1:0] eccRdData,
  output logic eccCorrected,
  output logic eccFatal,
  output logic memClk_ff,
  input wire logic [MODE_W-1:0] dqIn,
  output logic [MODE_W-1:0] dqOut_ff,
  output logic [MODE_W-1:0] dqOe_ff,
  input wire logic strobeIn,
  output logic strobeOut_ff,
  output logic strobeOe_ff,
  output logic write_mask_ff,
  input wire logic read_valid_flag
);

  localparam int LINES = DATA_W + (PARITY_EN ? DATA_W / 8 : 0);

  initial
  begin
    if (LINES < 1 || LINES > MODE_X32 || MODE_W != groupMode(LINES) ||
        (PARITY_EN && DATA_W % 8 != 0) || MCLK_HALF < 4 ||
        MCLK_HALF > 255 || SETTLE < 1 || SETTLE >= (1 << SETTLE_W))
      $error("ddrsg_datapath: unsupported parameter values");
  end

  // Data lines in line order, parity bits above the data
  function automatic logic [MODE_W-1:0] lineWord(input logic [DATA_W-1:0] d);
    logic [MODE_W-1:0] w;
    w = '0;
    w[DATA_W-1:0] = d;
    if (PARITY_EN)
      for (int b = 0; b < DATA_W / 8; b++)
        w[DATA_W + b] = ^d[b*8 +: 8];
    return w;
  endfunction : lineWord

  // ----------------------------------------------------------------
  // Registers over Wishbone
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic perr_ff;
  logic settled_ff;
  logic armed_ff;
  logic [BEAT_W-1:0] beats_ff;
  logic perrSet;
  logic busHit;
  logic capEnable;
  logic readClockMode;
  logic [SHIFT_W-1:0] shiftSel;

  assign busHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign capEnable = ctrl_ff[CTRL_CAPEN_BIT];
  assign readClockMode = ctrl_ff[CTRL_RDCLK_BIT];
  assign shiftSel = ctrl_ff[CTRL_SHIFT_LSB +: SHIFT_W];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_ff <= CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= busHit;
      if (busHit && wb_we_i && wb_adr_i == REG_CTRL)
        for (int i = 0; i < 2; i++)
          if (wb_sel_i[i])
            ctrl_ff[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
      wb_dat_o <= '0;
      if (busHit && !wb_we_i && wb_adr_i == REG_CTRL)
        wb_dat_o <= {16'h0000, ctrl_ff[15:8], 6'h00, ctrl_ff[1:0]};
      if (busHit && !wb_we_i && wb_adr_i == REG_STATUS)
      begin
        wb_dat_o[STAT_BEATS_LSB +: BEAT_W] <= beats_ff;
        wb_dat_o[STAT_PERR_BIT] <= perr_ff;
        wb_dat_o[STAT_ARMED_BIT] <= armed_ff;
        wb_dat_o[STAT_SETTLED_BIT] <= settled_ff;
      end
    end
  end

  // Parity error is sticky; a new error beats a write-one clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      perr_ff <= 1'b0;
    else if (perrSet)
      perr_ff <= 1'b1;
    else if (busHit && wb_we_i && wb_adr_i == REG_STATUS && wb_sel_i[0] &&
             wb_dat_i[STAT_PERR_BIT])
      perr_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Memory clock, write launch points and phase loop settling
  // ----------------------------------------------------------------
  logic [7:0] divCnt_ff;
  logic [SETTLE_W-1:0] settleCnt_ff;
  logic halfTick;
  logic launchTick;

  assign halfTick = divCnt_ff == 8'(MCLK_HALF - 1);
  // Minus ninety degrees: mid-way through each half period
  assign launchTick = divCnt_ff == 8'(MCLK_HALF / 2 - 1);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      divCnt_ff <= '0;
      memClk_ff <= 1'b0;
    end
    else
    begin
      divCnt_ff <= halfTick ? 8'h00 : divCnt_ff + 8'h01;
      if (halfTick)
        memClk_ff <= !memClk_ff;
    end
  end

  // The memory clock doubles as the phase loop reference
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      settleCnt_ff <= '0;
      settled_ff <= 1'b0;
    end
    else if (!settled_ff && halfTick && !memClk_ff)
    begin
      settleCnt_ff <= settleCnt_ff + 9'h001;
      settled_ff <= settleCnt_ff == SETTLE_W'(SETTLE - 1);
    end
  end

  // ----------------------------------------------------------------
  // Write path: one holding stage, launched at quarter points
  // ----------------------------------------------------------------
  logic holdFull_ff;
  logic [MODE_W-1:0] holdLines_ff;
  logic holdSkip_ff;
  logic accept;
  logic launch;
  logic nxt_holdFull;

  assign accept = wrValid && wrReady_ff;
  assign launch = launchTick && holdFull_ff && !armed_ff;
  assign nxt_holdFull = accept || (holdFull_ff && !launch);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      holdFull_ff <= 1'b0;
      wrReady_ff <= 1'b0;
      holdLines_ff <= '0;
      holdSkip_ff <= 1'b1;
    end
    else
    begin
      holdFull_ff <= nxt_holdFull;
      wrReady_ff <= !nxt_holdFull;
      if (accept)
      begin
        holdLines_ff <= lineWord(wrData);
        holdSkip_ff <= wrSkip;
      end
    end
  end

  // Mask and data share the launch register timing
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dqOut_ff <= '0;
      dqOe_ff <= '0;
      write_mask_ff <= 1'b1;
      strobeOut_ff <= 1'b0;
      strobeOe_ff <= 1'b0;
    end
    else
    begin
      if (launchTick)
      begin
        dqOut_ff <= launch ? holdLines_ff : '0;
        write_mask_ff <= launch ? holdSkip_ff : 1'b1;
        for (int i = 0; i < MODE_W; i++)
          dqOe_ff[i] <= launch && capEnable && i < LINES;
        strobeOe_ff <= launch && capEnable && !readClockMode;
      end
      // Enables drop at once, not only at the next launch point
      if (!capEnable)
        dqOe_ff <= '0;
      if (!capEnable || readClockMode)
        strobeOe_ff <= 1'b0;
      strobeOut_ff <= memClk_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read path: synchronise, delay by the phase shift, capture
  // ----------------------------------------------------------------
  logic [2:0] strobeSync_ff;
  logic [MODE_W-1:0] dqSync1_ff;
  logic [MODE_W-1:0] dqSync2_ff;
  logic [MODE_W-1:0] dqSync3_ff;
  logic [2:0] flagSync_ff;
  logic [SHIFT_W-1:0] shiftCnt_ff;
  logic capPending_ff;
  logic prevFlag_ff;
  logic strobeEdge;
  logic capNow;
  logic beatOk;

  // Both strobe edges count: the inverted copy clocks the opposite phase
  assign strobeEdge = strobeSync_ff[2] != strobeSync_ff[1];
  assign capNow = armed_ff && capEnable &&
    ((strobeEdge && shiftSel == '0) ||
     (capPending_ff && shiftCnt_ff == 8'h01));
  // Flag leads data by one beat, so a beat counts if the flag stood before
  assign beatOk = capNow && prevFlag_ff;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strobeSync_ff <= '0;
      dqSync1_ff <= '0;
      dqSync2_ff <= '0;
      dqSync3_ff <= '0;
      flagSync_ff <= '0;
    end
    else
    begin
      strobeSync_ff <= {strobeSync_ff[1:0], strobeIn};
      dqSync1_ff <= dqIn;
      dqSync2_ff <= dqSync1_ff;
      dqSync3_ff <= dqSync2_ff;
      flagSync_ff <= {flagSync_ff[1:0], read_valid_flag};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shiftCnt_ff <= '0;
      capPending_ff <= 1'b0;
    end
    else if (strobeEdge && shiftSel != '0)
    begin
      shiftCnt_ff <= shiftSel;
      capPending_ff <= 1'b1;
    end
    else if (capPending_ff)
    begin
      shiftCnt_ff <= shiftCnt_ff - 8'h01;
      capPending_ff <= shiftCnt_ff != 8'h01;
    end
  end

  // A read is armed only after settling and ends after the last beat
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      armed_ff <= 1'b0;
      rdAllowed_ff <= 1'b0;
      prevFlag_ff <= 1'b0;
      beats_ff <= '0;
      rdData_ff <= '0;
      rdValid_ff <= 1'b0;
      perrSet <= 1'b0;
    end
    else
    begin
      rdValid_ff <= beatOk;
      perrSet <= 1'b0;
      if (rdStart && rdAllowed_ff && capEnable && !holdFull_ff)
      begin
        armed_ff <= 1'b1;
        beats_ff <= '0;
        prevFlag_ff <= 1'b0;
      end
      else if (capNow)
      begin
        prevFlag_ff <= flagSync_ff[2];
        if (prevFlag_ff && !flagSync_ff[2])
          armed_ff <= 1'b0;
      end
      rdAllowed_ff <= settled_ff && !armed_ff && !(rdStart && rdAllowed_ff);
      if (beatOk)
      begin
        rdData_ff <= dqSync3_ff[DATA_W-1:0];
        beats_ff <= beats_ff + 16'h0001;
        perrSet <= PARITY_EN &&
          dqSync3_ff != lineWord(dqSync3_ff[DATA_W-1:0]);
      end
    end
  end

  ddrsg_secded u_secded (
    .clk(clk),
    .reset(reset),
    .encData(eccWrData),
    .encCode_ff(eccWrCode),
    .decCode(eccRdCode),
    .decData_ff(eccRdData),
    .decCorrected_ff(eccCorrected),
    .decFatal_ff(eccFatal)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_noReadUnsettled;
    @(posedge clk) disable iff (reset) armed_ff |-> settled_ff;
  endproperty
  a_noReadUnsettled: assert property (p_noReadUnsettled)
    else $error("Read armed before the phase loop settled");

  property p_settleCount;
    @(posedge clk) disable iff (reset)
      $rose(settled_ff) |-> settleCnt_ff == SETTLE_W'(SETTLE);
  endproperty
  a_settleCount: assert property (p_settleCount)
    else $error("Settling ended at the wrong reference count");

  property p_inputOnly;
    @(posedge clk) disable iff (reset)
      !capEnable && $past(!capEnable) |=> dqOe_ff == '0 && !strobeOe_ff;
  endproperty
  a_inputOnly: assert property (p_inputOnly)
    else $error("Output enable raised while capture is off");

  property p_maskWithData;
    @(posedge clk) disable iff (reset)
      $changed(write_mask_ff) || $changed(dqOut_ff) |-> $past(launchTick);
  endproperty
  a_maskWithData: assert property (p_maskWithData)
    else $error("Mask or data changed off the launch point");

  property p_maskIdle;
    @(posedge clk) disable iff (reset)
      !write_mask_ff |-> dqOe_ff[0] || !capEnable;
  endproperty
  a_maskIdle: assert property (p_maskIdle)
    else $error("Mask low outside a write beat");

  property p_readClockQuiet;
    @(posedge clk) disable iff (reset)
      strobeOe_ff |-> !$past(readClockMode);
  endproperty
  a_readClockQuiet: assert property (p_readClockQuiet)
    else $error("Strobe driven in read clock mode");

  property p_clockHalf;
    @(posedge clk) disable iff (reset)
      $changed(memClk_ff) |-> $past(divCnt_ff) == 8'(MCLK_HALF - 1);
  endproperty
  a_clockHalf: assert property (p_clockHalf)
    else $error("Memory clock half period wrong");

  property p_beatAfterFlag;
    @(posedge clk) disable iff (reset)
      rdValid_ff |-> $past(prevFlag_ff) && $past(capNow);
  endproperty
  a_beatAfterFlag: assert property (p_beatAfterFlag)
    else $error("Beat delivered without a prior valid flag");

  property p_surplusLines;
    @(posedge clk) disable iff (reset)
      dqOe_ff[0] |-> dqOe_ff == MODE_W'((64'h1 << LINES) - 64'h1);
  endproperty
  a_surplusLines: assert property (p_surplusLines)
    else $error("Surplus line driven on the strobe bus");

  c_write: cover property (@(posedge clk) disable iff (reset) launch);
  c_beat: cover property (@(posedge clk) disable iff (reset) rdValid_ff);
  c_settle: cover property (@(posedge clk) disable iff (reset)
    $rose(settled_ff));

endmodule : ddrsg_datapath

// ### design/ddrsg_pkg.sv
// Shared constants for the strobe group data path: register map, field
// positions, reset values, timing counts and the group width decode.
// Assumes a 250 MHz core clock and a Wishbone classic register port.
package ddrsg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_CAPEN_BIT = 0;
  localparam int CTRL_RDCLK_BIT = 1;
  localparam int CTRL_SHIFT_LSB = 8;
  localparam int SHIFT_W = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0a01;
  localparam int STAT_SETTLED_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_PERR_BIT = 2;
  localparam int STAT_BEATS_LSB = 16;
  localparam int BEAT_W = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int MCLK_PERIOD_NS = 160;
  localparam int MCLK_HALF_CYC = MCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SETTLE_REF_CYCLES = 256;
  localparam int SETTLE_W = 9;

  // ----------------------------------------------------------------
  // Group widths and check code
  // ----------------------------------------------------------------
  localparam int MODE_X8 = 8;
  localparam int MODE_X16 = 16;
  localparam int MODE_X32 = 32;
  localparam int ECC_DATA_W = 64;
  localparam int ECC_CODE_W = 72;
  localparam int ECC_CHK_W = 7;

  // Odd widths round up to the next supported grouping
  function automatic int groupMode(input int lines);
    if (lines <= MODE_X8)
      return MODE_X8;
    else if (lines <= MODE_X16)
      return MODE_X16;
    else
      return MODE_X32;
  endfunction : groupMode

endpackage : ddrsg_pkg

// ### design/ddrsg_secded.sv
// Single-error-correct, double-error-detect coder for a 72-bit memory word:
// 64 data bits plus 8 check bits. Both results leave through registers.
// Assumes the caller places the 72-bit code on strobe groups itself.
`timescale 1ns/1ns
module ddrsg_secded
  import ddrsg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ddrsg_pkg::ECC_DATA_W-1:0] encData,
  output logic [ddrsg_pkg::ECC_CODE_W-1:0] encCode_ff,
  input wire logic [ddrsg_pkg::ECC_CODE_W-1:0] decCode,
  output logic [ddrsg_pkg::ECC_DATA_W-1:0] decData_ff,
  output logic decCorrected_ff,
  output logic decFatal_ff
);

  // ----------------------------------------------------------------
  // Code arithmetic
  // ----------------------------------------------------------------
  // Hamming positions 1..71, check bits at powers of two, bit 0 overall
  function automatic logic [ECC_CHK_W-1:0] syndrome(input logic [71:0] c);
    logic [ECC_CHK_W-1:0] s;
    s = '0;
    for (int i = 1; i < ECC_CODE_W; i++)
      for (int p = 0; p < ECC_CHK_W; p++)
        if (i[p])
          s[p] = s[p] ^ c[i];
    return s;
  endfunction : syndrome

  function automatic logic [71:0] encode(input logic [63:0] d);
    logic [71:0] c;
    logic [ECC_CHK_W-1:0] s;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < ECC_CODE_W; i++)
      if ((i & (i - 1)) != 0)
      begin
        c[i] = d[k];
        k++;
      end
    s = syndrome(c);
    for (int p = 0; p < ECC_CHK_W; p++)
      c[1 << p] = s[p];
    c[0] = ^c[71:1];
    return c;
  endfunction : encode

  function automatic logic [63:0] extract(input logic [71:0] c);
    logic [63:0] d;
    int k;
    d = '0;
    k = 0;
    for (int i = 1; i < ECC_CODE_W; i++)
      if ((i & (i - 1)) != 0)
      begin
        d[k] = c[i];
        k++;
      end
    return d;
  endfunction : extract

  logic [ECC_CHK_W-1:0] syn;
  logic overall;
  logic [71:0] fixed;

  always_comb
  begin
    syn = syndrome(decCode);
    overall = ^decCode;
    fixed = decCode;
    if (overall && syn < 7'(ECC_CODE_W))
      fixed[syn] = ~decCode[syn];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      encCode_ff <= '0;
      decData_ff <= '0;
      decCorrected_ff <= 1'b0;
      decFatal_ff <= 1'b0;
    end
    else
    begin
      encCode_ff <= encode(encData);
      decData_ff <= extract(fixed);
      decCorrected_ff <= overall;
      decFatal_ff <= !overall && syn != '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_eccRoundTrip;
    @(posedge clk) disable iff (reset)
      decCode == encCode_ff |=> !decCorrected_ff && !decFatal_ff;
  endproperty
  a_eccRoundTrip: assert property (p_eccRoundTrip)
    else $error("Clean check code reported as an error");

endmodule : ddrsg_secded

// ### verification/ddrsg_datapath_tb.sv
// Self-checking bench for one byte group with parity, shortened counts.
// Assumes the memory model is the only driver of the pin inputs.
`timescale 1ns/1ns
module ddrsg_datapath_tb;
  import ddrsg_pkg::*;
  localparam int HALF = 4;
  localparam int SET = 4;
  logic clk, reset, wbWe, wbCyc, wbStb, wbAck;
  logic [7:0] wbAdr, wrData, rdData;
  logic [31:0] wbDatI, wbDatO;
  logic [3:0] wbSel;
  logic wrValid, wrReady, wrSkip, rdStart, rdAllowed, rdValid;
  logic [63:0] eccWrData, eccRdData;
  logic [71:0] eccWrCode, eccRdCode;
  logic eccCorrected, eccFatal, memClk, strobeIn, flag, writeMask;
  logic strobeOut, strobeOe;
  logic [15:0] dqIn, dqOut, dqOe;
  int mismatches, testsRun, cycles, beats;
  logic [7:0] got [0:7];

  ddrsg_datapath #(.DATA_W(8), .PARITY_EN(1'b1), .MCLK_HALF(HALF),
    .SETTLE(SET)) dut (.clk(clk), .reset(reset), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_we_i(wbWe),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .wrValid(wrValid), .wrReady_ff(wrReady),
    .wrData(wrData), .wrSkip(wrSkip), .rdStart(rdStart),
    .rdAllowed_ff(rdAllowed), .rdData_ff(rdData), .rdValid_ff(rdValid),
    .eccWrData(eccWrData), .eccWrCode(eccWrCode),
    .eccRdCode(eccRdCode), .eccRdData(eccRdData),
    .eccCorrected(eccCorrected), .eccFatal(eccFatal),
    .memClk_ff(memClk), .dqIn(dqIn), .dqOut_ff(dqOut), .dqOe_ff(dqOe),
    .strobeIn(strobeIn), .strobeOut_ff(strobeOut), .strobeOe_ff(strobeOe),
    .write_mask_ff(writeMask), .read_valid_flag(flag));

  ddrsg_mem_model mem (.strobe(strobeIn), .dq(dqIn), .validFlag(flag));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Beats are sampled off the edge so the pulse is seen exactly once
  always @(negedge clk)
    if (rdValid === 1'b1)
    begin
      if (beats < 8)
        got[beats] = rdData;
      beats++;
    end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [71:0] exp,
                     input logic [71:0] seen);
    testsRun++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d, output logic [31:0] q);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= d;
    // No limit of its own: if no acknowledge comes, the bench timeout ends this wait
    do
      @(posedge clk);
    while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic results();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    int n;
    n = 0;
    chk("mask idle", 1, writeMask);
    rdStart <= 1'b1;
    @(posedge clk);
    rdStart <= 1'b0;
    repeat (16) @(posedge clk);
    chk("early allowed", 0, rdAllowed);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("early armed", 0, q[STAT_ARMED_BIT]);
    while (rdAllowed !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk("settled allowed", 1, rdAllowed);
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl reset", CTRL_RESET, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("unmapped read", 0, q);
    $display("reset test done");
  endtask : t_reset

  task automatic t_memclk();
    int n;
    n = 0;
    // Start on a rising edge so the count covers whole phases
    while (memClk !== 1'b0)
      @(posedge clk);
    while (memClk !== 1'b1)
      @(posedge clk);
    chk("strobe copy lag", 0, strobeOut);
    @(posedge clk);
    n = 1;
    chk("strobe copy", 1, strobeOut);
    while (memClk !== 1'b0)
    begin
      @(posedge clk);
      n++;
    end
    while (memClk !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    chk("memory clock period", 2 * HALF, n);
    $display("memory clock test done");
  endtask : t_memclk

  task automatic beat(input logic [7:0] d, input logic skip,
                      input logic drive);
    int n;
    n = 0;
    wrValid <= 1'b1;
    wrData <= d;
    wrSkip <= skip;
    do
      @(posedge clk);
    while (wrReady !== 1'b1);
    wrValid <= 1'b0;
    while (!(dqOe[0] === 1'b1 && dqOut[7:0] === d) && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk("beat data", d, dqOut[7:0]);
    chk("beat mask", skip, writeMask);
    chk("parity line", ^d, dqOut[8]);
    chk("group enables", 16'h01ff, dqOe);
    chk("strobe drive", drive, strobeOe);
  endtask : beat

  task automatic t_write();
    beat(8'h07, 1'b0, 1'b1);
    beat(8'h3c, 1'b1, 1'b1);
    beat(8'hc1, 1'b0, 1'b1);
    $display("write test done");
  endtask : t_write

  task automatic t_ecc();
    logic [63:0] d;
    d = 64'h0123_4567_89ab_cdef;
    eccWrData <= d;
    repeat (2) @(posedge clk);
    eccRdCode <= eccWrCode;
    repeat (2) @(posedge clk);
    chk("ecc clean data", d, eccRdData);
    chk("ecc clean flags", 0, {eccCorrected, eccFatal});
    eccRdCode <= eccWrCode ^ 72'h20;
    repeat (2) @(posedge clk);
    chk("ecc single data", d, eccRdData);
    chk("ecc corrected", 1, eccCorrected);
    eccRdCode <= eccWrCode ^ 72'h30;
    repeat (2) @(posedge clk);
    chk("ecc double fatal", 1, eccFatal);
    $display("check bit test done");
  endtask : t_ecc

  task automatic t_inonly();
    logic [31:0] q;
    // Read clock mode: data still driven, strobe pin left to the memory
    wb(1'b1, REG_CTRL, 32'h0000_0a03, q);
    beat(8'h5a, 1'b0, 1'b0);
    wb(1'b1, REG_CTRL, 32'h0000_0a00, q);
    rdStart <= 1'b1;
    @(posedge clk);
    rdStart <= 1'b0;
    repeat (2) @(posedge clk);
    chk("input only enables", 0, {dqOe, strobeOe});
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("armed input only", 0, q[STAT_ARMED_BIT]);
    wb(1'b1, REG_CTRL, CTRL_RESET, q);
    $display("input only test done");
  endtask : t_inonly

  task automatic t_read();
    logic [31:0] q;
    beats = 0;
    rdStart <= 1'b1;
    @(posedge clk);
    rdStart <= 1'b0;
    #1 mem.burst(3);
    repeat (40) @(posedge clk);
    chk("beat count", 3, beats);
    for (int k = 0; k < 3; k++)
      chk("read beat", 8'h51 + 8'(k), got[k]);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("status beats", 3, q[31:16]);
    chk("parity clean", 0, q[STAT_PERR_BIT]);
    chk("allowed again", 1, rdAllowed);
    $display("read test done");
  endtask : t_read

  initial
  begin
    reset = 1'b1;
    {wbWe, wbCyc, wbStb, wrValid, wrSkip, rdStart} = 6'h00;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    wbSel = 4'hf;
    wrData = 8'h00;
    eccWrData = 64'h0;
    eccRdCode = 72'h0;
    mismatches = 0;
    testsRun = 0;
    cycles = 0;
    beats = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_memclk();
    t_write();
    t_ecc();
    t_inonly();
    t_read();
    results();
  end
endmodule : ddrsg_datapath_tb

// ### verification/ddrsg_mem_model.sv
// Behavioural memory chip on the far side: returns one read burst.
// Assumes the bench calls burst() and nothing else drives these pins.
`timescale 1ns/1ns
module ddrsg_mem_model
(
  output logic strobe,
  output logic [15:0] dq,
  output logic validFlag
);
  initial
  begin
    strobe = 1'b0;
    dq = 16'h0000;
    validFlag = 1'b0;
  end

  // Read clock stands still between bursts; released lines invert
  task automatic burst(input int n);
    logic [7:0] d;
    validFlag = 1'b1;
    strobe = 1'b1;
    dq = ~dq;
    for (int k = 1; k <= n; k++)
    begin
      #80;
      d = 8'h50 + 8'(k);
      strobe = ~strobe;
      dq = {7'h00, ^d, d};
      validFlag = (k < n);
    end
    #80;
    dq = ~dq;
  endtask : burst
endmodule : ddrsg_mem_model
